// file: hdl/efb_coef_bank.sv
`timescale 1ns/10ps
`default_nettype none


module efb_coef_bank import efb_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [EFB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ECHO_VALID,
  input wire logic signed [EFB_DW-1:0] ECHO_DATA,
  output logic BP_VALID,
  output logic signed [EFB_DW-1:0] BP_DATA,
  output logic LP_VALID,
  output logic signed [EFB_DW-1:0] LP_DATA
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    efb_apb_e st;
    logic [EFB_NREG-1:0][7:0] regs;
    logic [31:0] rdata;
    logic slverr;
  } efb_bank_s;

  efb_bank_s st_r;
  efb_bank_s st_nxt;

  logic [3:0] slot;
  logic setup;
  logic access;
  logic [7:0] rd_byte;
  logic [EFB_BP_CW-1:0] bandpass_b1_coef;
  logic [EFB_BP_CW-1:0] bandpass_a2_coef;
  logic [EFB_BP_CW-1:0] bandpass_a3_coef;
  logic [EFB_LP_CW-1:0] lowpass_b1_coef;
  logic [EFB_LP_CW-1:0] lowpass_a2_coef;

  efb_iir_if bp_if ();
  efb_iir_if lp_if ();

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Word aligned only; a byte address that is not a multiple of four
  // misses, so a stray byte pointer cannot alias a coefficient.
  function automatic logic [3:0] efb_decode(input logic [EFB_AW-1:0] a);
    logic [3:0] s;
    s = EFB_S_MISS;
    for (int i = 0; i < EFB_NREG; i++) begin
      if (a[1:0] == 2'b00 && a[EFB_AW-1:2] == {2'b00, EFB_IDX_TAB[i]}) begin
        s = i[3:0];
      end
    end
    efb_decode = s;
  endfunction

  function automatic logic [EFB_AW-1:0] efb_addr(input logic [7:0] idx);
    efb_addr = {2'b00, idx, 2'b00};
  endfunction

  assign slot = efb_decode(PADDR);
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && (st_r.st == EFB_AP_ACCESS);
  assign rd_byte = (slot == EFB_S_MISS) ? EFB_BYTE_RST : st_r.regs[slot];

  // ****************************************************************
  // Bus slave and register file
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r.st)
      EFB_AP_IDLE: begin
        if (setup) begin
          st_nxt.st = EFB_AP_ACCESS;
          st_nxt.slverr = (slot == EFB_S_MISS);
          st_nxt.rdata = PWRITE ? EFB_RDATA_RST : {24'h00_0000, rd_byte};
        end
      end
      EFB_AP_ACCESS: begin
        if (access) begin
          st_nxt.st = EFB_AP_IDLE;
          st_nxt.slverr = 1'b0;
          st_nxt.rdata = EFB_RDATA_RST;
          // Whole byte only, upper write lanes are dropped
          if (PWRITE && slot != EFB_S_MISS) begin
            st_nxt.regs[slot] = PWDATA[7:0];
          end
        end else if (!PSEL) begin
          st_nxt.st = EFB_AP_IDLE;
          st_nxt.slverr = 1'b0;
          st_nxt.rdata = EFB_RDATA_RST;
        end
      end
      default: begin
        st_nxt.st = EFB_AP_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_r.st <= EFB_AP_IDLE;
      st_r.regs <= {EFB_NREG{EFB_BYTE_RST}};
      st_r.rdata <= EFB_RDATA_RST;
      st_r.slverr <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Zero wait states: ready in the first access cycle
  assign PREADY = (st_r.st == EFB_AP_ACCESS);
  assign PRDATA = st_r.rdata;
  assign PSLVERR = st_r.slverr && PREADY;

  // ****************************************************************
  // Coefficient assembly
  // ****************************************************************
  assign bandpass_b1_coef = {st_r.regs[EFB_S_BP_B1_HI], st_r.regs[EFB_S_BP_B1_LO]};
  assign bandpass_a2_coef = {st_r.regs[EFB_S_BP_A2_HI], st_r.regs[EFB_S_BP_A2_LO]};
  assign bandpass_a3_coef = {st_r.regs[EFB_S_BP_A3_HI], st_r.regs[EFB_S_BP_A3_LO]};
  // Bit 7 of the high byte is kept for read-back but never reaches the filter
  assign lowpass_b1_coef = {st_r.regs[EFB_S_LP_B1_HI][6:0], st_r.regs[EFB_S_LP_B1_LO]};
  assign lowpass_a2_coef = {st_r.regs[EFB_S_LP_A2_HI][6:0], st_r.regs[EFB_S_LP_A2_LO]};

  // ****************************************************************
  // Bandpass section: b0 = B1, b2 = -B1, poles A2 and A3
  // ****************************************************************
  // Coefficients are read live, so a write lands on the next sample taken
  assign bp_if.b0 = bandpass_b1_coef;
  assign bp_if.b1 = '0;
  assign bp_if.b2 = -bandpass_b1_coef;
  assign bp_if.a1 = bandpass_a2_coef;
  assign bp_if.a2 = bandpass_a3_coef;
  assign bp_if.x = ECHO_DATA;
  assign bp_if.x_valid = ECHO_VALID;

  efb_iir_section u_bandpass (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .io(bp_if.sect)
  );

  // ****************************************************************
  // Lowpass section: b0 = b1 = B1, single pole A2
  // ****************************************************************
  // Fed with the bandpass output; sample rate reduction happens
  // upstream of the valid strobe and is not checked here.
  assign lp_if.b0 = {lowpass_b1_coef[EFB_LP_CW-1], lowpass_b1_coef};
  assign lp_if.b1 = {lowpass_b1_coef[EFB_LP_CW-1], lowpass_b1_coef};
  assign lp_if.b2 = '0;
  assign lp_if.a1 = {lowpass_a2_coef[EFB_LP_CW-1], lowpass_a2_coef};
  assign lp_if.a2 = '0;
  assign lp_if.x = bp_if.y;
  assign lp_if.x_valid = bp_if.y_valid;

  efb_iir_section u_lowpass (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .io(lp_if.sect)
  );

  assign BP_VALID = bp_if.y_valid;
  assign BP_DATA = bp_if.y;
  assign LP_VALID = lp_if.y_valid;
  assign LP_DATA = lp_if.y;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_wr_done(logic [EFB_AW-1:0] a);
    PSEL && PENABLE && PREADY && PWRITE && PADDR == a;
  endsequence

  sequence s_rd_setup;
    PSEL && !PENABLE && !PWRITE && slot != EFB_S_MISS && st_r.st == EFB_AP_IDLE;
  endsequence

  sequence s_chain;
    BP_VALID ##1 LP_VALID;
  endsequence

  chk_bp_b1_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_wr_done(efb_addr(EFB_BP_B1_HI_IDX)) |=>
      bandpass_b1_coef == {$past(PWDATA[7:0]), $past(bandpass_b1_coef[7:0])})
    else $error("bandpass b1 high byte not stored");

  chk_bp_a2_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_wr_done(efb_addr(EFB_BP_A2_LO_IDX)) |=>
      bandpass_a2_coef == {$past(bandpass_a2_coef[15:8]), $past(PWDATA[7:0])})
    else $error("bandpass a2 low byte not stored");

  chk_bp_a3_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_wr_done(efb_addr(EFB_BP_A3_HI_IDX)) |=>
      bp_if.a2 == {$past(PWDATA[7:0]), $past(bandpass_a3_coef[7:0])})
    else $error("bandpass a3 high byte not applied");

  chk_lp_b1_layout: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_wr_done(efb_addr(EFB_LP_B1_HI_IDX)) |=>
      lowpass_b1_coef[14:8] == $past(PWDATA[6:0])
      && lowpass_b1_coef[7:0] == $past(lowpass_b1_coef[7:0]))
    else $error("lowpass b1 high byte misplaced");

  chk_lp_a2_layout: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_wr_done(efb_addr(EFB_LP_A2_LO_IDX)) |=>
      lowpass_a2_coef == {$past(lowpass_a2_coef[14:8]), $past(PWDATA[7:0])})
    else $error("lowpass a2 low byte misplaced");

  chk_bp_b1_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_wr_done(efb_addr(EFB_BP_B1_LO_IDX)) |=>
      bandpass_b1_coef == {$past(bandpass_b1_coef[15:8]), $past(PWDATA[7:0])})
    else $error("bandpass b1 low byte not stored");

  chk_bp_a2_high: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_wr_done(efb_addr(EFB_BP_A2_HI_IDX)) |=>
      bp_if.a1 == {$past(PWDATA[7:0]), $past(bandpass_a2_coef[7:0])})
    else $error("bandpass a2 high byte not applied");

  chk_bp_a3_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_wr_done(efb_addr(EFB_BP_A3_LO_IDX)) |=>
      bandpass_a3_coef == {$past(bandpass_a3_coef[15:8]), $past(PWDATA[7:0])})
    else $error("bandpass a3 low byte not stored");

  chk_lp_b1_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_wr_done(efb_addr(EFB_LP_B1_LO_IDX)) |=>
      lowpass_b1_coef == {$past(lowpass_b1_coef[14:8]), $past(PWDATA[7:0])})
    else $error("lowpass b1 low byte misplaced");

  chk_lp_a2_high: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_wr_done(efb_addr(EFB_LP_A2_HI_IDX)) |=>
      lowpass_a2_coef[14:8] == $past(PWDATA[6:0])
      && lowpass_a2_coef[7:0] == $past(lowpass_a2_coef[7:0]))
    else $error("lowpass a2 high byte misplaced");

  // A refused write must leave every byte alone
  chk_miss_no_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (PSEL && PENABLE && PREADY && PWRITE && slot == EFB_S_MISS) |=> $stable(st_r.regs))
    else $error("unmapped write changed a register");

  chk_ready_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    PREADY |=> !PREADY)
    else $error("ready stood longer than one cycle");

  chk_rdata_idle: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !PREADY |-> PRDATA == EFB_RDATA_RST)
    else $error("read data not zero outside access");

  chk_bp_no_stray: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !ECHO_VALID |=> !BP_VALID)
    else $error("bandpass output without a sample");

  chk_reset_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(RST_N) |-> bandpass_b1_coef == '0 && bandpass_a2_coef == '0
      && bandpass_a3_coef == '0 && lowpass_b1_coef == '0 && lowpass_a2_coef == '0
      && !PREADY)
    else $error("coefficients not zero after reset");

  chk_read_back: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_rd_setup |=> PREADY && PRDATA == {24'h00_0000, $past(rd_byte)} && !PSLVERR)
    else $error("read data differs from stored byte");

  chk_miss_error: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (setup && st_r.st == EFB_AP_IDLE && slot == EFB_S_MISS) |=> PREADY && PSLVERR)
    else $error("unmapped access not flagged");

  chk_sample_chain: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ECHO_VALID |=> s_chain)
    else $error("sample did not pass both sections in two cycles");

  chk_live_coef: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ECHO_VALID && bandpass_b1_coef == '0 && $past(BP_DATA) == '0
      && bandpass_a2_coef == '0 && bandpass_a3_coef == '0 |=> BP_DATA == '0)
    else $error("zero coefficients gave nonzero output");

endmodule

`default_nettype wire

// file: hdl/efb_pkg.sv
package efb_pkg;

  // ****************************************************************
  // Datapath sizes
  // ****************************************************************
  localparam int EFB_DW = 16;
  localparam int EFB_BP_CW = 16;
  localparam int EFB_LP_CW = 15;
  localparam int EFB_FRAC = 14;
  localparam int EFB_ACC_W = 35;

  // ****************************************************************
  // Register map: printed offsets are indices, byte address is 4x
  // ****************************************************************
  localparam int EFB_NREG = 10;
  localparam int EFB_AW = 12;
  localparam logic [7:0] EFB_BP_B1_HI_IDX = 8'h92;
  localparam logic [7:0] EFB_BP_B1_LO_IDX = 8'h93;
  localparam logic [7:0] EFB_BP_A2_HI_IDX = 8'h94;
  localparam logic [7:0] EFB_BP_A2_LO_IDX = 8'h95;
  localparam logic [7:0] EFB_BP_A3_HI_IDX = 8'h96;
  localparam logic [7:0] EFB_BP_A3_LO_IDX = 8'h97;
  localparam logic [7:0] EFB_LP_B1_HI_IDX = 8'hA1;
  localparam logic [7:0] EFB_LP_B1_LO_IDX = 8'hA2;
  localparam logic [7:0] EFB_LP_A2_HI_IDX = 8'hA3;
  localparam logic [7:0] EFB_LP_A2_LO_IDX = 8'hA4;

  // Slot order inside the register array
  localparam logic [3:0] EFB_S_BP_B1_HI = 4'h0;
  localparam logic [3:0] EFB_S_BP_B1_LO = 4'h1;
  localparam logic [3:0] EFB_S_BP_A2_HI = 4'h2;
  localparam logic [3:0] EFB_S_BP_A2_LO = 4'h3;
  localparam logic [3:0] EFB_S_BP_A3_HI = 4'h4;
  localparam logic [3:0] EFB_S_BP_A3_LO = 4'h5;
  localparam logic [3:0] EFB_S_LP_B1_HI = 4'h6;
  localparam logic [3:0] EFB_S_LP_B1_LO = 4'h7;
  localparam logic [3:0] EFB_S_LP_A2_HI = 4'h8;
  localparam logic [3:0] EFB_S_LP_A2_LO = 4'h9;
  localparam logic [3:0] EFB_S_MISS = 4'hA;

  localparam logic [7:0] EFB_IDX_TAB [EFB_NREG] = '{
    EFB_BP_B1_HI_IDX, EFB_BP_B1_LO_IDX, EFB_BP_A2_HI_IDX, EFB_BP_A2_LO_IDX,
    EFB_BP_A3_HI_IDX, EFB_BP_A3_LO_IDX, EFB_LP_B1_HI_IDX, EFB_LP_B1_LO_IDX,
    EFB_LP_A2_HI_IDX, EFB_LP_A2_LO_IDX};

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] EFB_BYTE_RST = 8'h00;
  localparam logic [31:0] EFB_RDATA_RST = 32'h0000_0000;

  // ****************************************************************
  // Bus slave states
  // ****************************************************************
  typedef enum logic [1:0] {
    EFB_AP_IDLE = 2'b00,
    EFB_AP_ACCESS = 2'b01
  } efb_apb_e;

endpackage

// file: hdl/efb_iir_if.sv
`timescale 1ns/10ps
`default_nettype none

interface efb_iir_if import efb_pkg::*; ();
  logic signed [EFB_DW-1:0] b0;
  logic signed [EFB_DW-1:0] b1;
  logic signed [EFB_DW-1:0] b2;
  logic signed [EFB_DW-1:0] a1;
  logic signed [EFB_DW-1:0] a2;
  logic signed [EFB_DW-1:0] x;
  logic x_valid;
  logic signed [EFB_DW-1:0] y;
  logic y_valid;

  modport src (output b0, b1, b2, a1, a2, x, x_valid, input y, y_valid);
  modport sect (input b0, b1, b2, a1, a2, x, x_valid, output y, y_valid);
endinterface

`default_nettype wire

// file: hdl/efb_iir_section.sv
`timescale 1ns/10ps
`default_nettype none

module efb_iir_section import efb_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  efb_iir_if.sect io
);

  typedef struct packed {
    logic signed [EFB_DW-1:0] x1;
    logic signed [EFB_DW-1:0] x2;
    logic signed [EFB_DW-1:0] y1;
    logic signed [EFB_DW-1:0] y2;
    logic signed [EFB_DW-1:0] y;
    logic yv;
  } efb_sect_s;

  efb_sect_s st_r;
  efb_sect_s st_nxt;
  logic signed [EFB_ACC_W-1:0] acc;

  // ****************************************************************
  // Saturating rescale
  // ****************************************************************
  // Clipping instead of wrapping keeps an unstable coefficient set from
  // flipping the sign of large echoes.
  function automatic logic signed [EFB_DW-1:0] efb_sat(input logic signed [EFB_ACC_W-1:0] a);
    logic signed [EFB_ACC_W-1:0] s;
    s = a >>> EFB_FRAC;
    if (s > EFB_ACC_W'(32767)) begin
      efb_sat = 16'sh7FFF;
    end else if (s < -EFB_ACC_W'(32768)) begin
      efb_sat = 16'sh8000;
    end else begin
      efb_sat = s[EFB_DW-1:0];
    end
  endfunction

  // ****************************************************************
  // Difference equation, one sample per valid
  // ****************************************************************
  always_comb begin
    acc = EFB_ACC_W'(io.b0 * io.x) + EFB_ACC_W'(io.b1 * st_r.x1)
        + EFB_ACC_W'(io.b2 * st_r.x2) - EFB_ACC_W'(io.a1 * st_r.y1)
        - EFB_ACC_W'(io.a2 * st_r.y2);
    st_nxt = st_r;
    st_nxt.yv = 1'b0;
    if (io.x_valid) begin
      st_nxt.x1 = io.x;
      st_nxt.x2 = st_r.x1;
      st_nxt.y1 = efb_sat(acc);
      st_nxt.y2 = st_r.y1;
      st_nxt.y = efb_sat(acc);
      st_nxt.yv = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign io.y = st_r.y;
  assign io.y_valid = st_r.yv;

endmodule

`default_nettype wire

// file: verification/efb_echo_src.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Echo sample source
// ****************************************************************
module efb_echo_src import efb_pkg::*; (
  input wire logic clk,
  output logic valid,
  output logic signed [EFB_DW-1:0] data
);
  initial begin
    valid = 1'b0;
    data = 16'h0000;
  end

  // Data not held after the strobe, so stale reuse shows up
  task automatic push(input logic signed [EFB_DW-1:0] x);
    @(posedge clk);
    valid <= 1'b1;
    data <= x;
    @(posedge clk);
    valid <= 1'b0;
    data <= ~x;
  endtask
endmodule

`default_nettype wire

// file: verification/efb_coef_bank_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module efb_coef_bank_tb_top import efb_pkg::*;;
  typedef struct {
    logic [7:0] idx;
    logic [31:0] wdata;
    logic [7:0] rexp;
    logic [7:0] fval;
  } efb_row_s;

  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic echo_valid, bp_valid, lp_valid, er;
  logic [EFB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [EFB_DW-1:0] echo_data, bp_data, lp_data;
  int num_errors = 0;
  int samples_checked = 0;
  // Upper write bits must drop; bit 7 of lowpass high bytes is kept
  efb_row_s rows [EFB_NREG] = '{
    '{8'h92, 32'hFFFF_FFA5, 8'hA5, 8'h40}, '{8'h93, 32'h0000_005A, 8'h5A, 8'h00},
    '{8'h94, 32'h0000_013C, 8'h3C, 8'h00}, '{8'h95, 32'h0000_00C3, 8'hC3, 8'h00},
    '{8'h96, 32'h0000_0081, 8'h81, 8'h00}, '{8'h97, 32'h0000_007E, 8'h7E, 8'h00},
    '{8'hA1, 32'h0000_00FF, 8'hFF, 8'h20}, '{8'hA2, 32'h0000_0001, 8'h01, 8'h00},
    '{8'hA3, 32'h0000_0080, 8'h80, 8'h00}, '{8'hA4, 32'h0000_00FE, 8'hFE, 8'h00}};
  // Q14: bandpass gain 1.0, lowpass 0.5, all feedback zero
  logic signed [15:0] xs [4] = '{16'sd100, 16'sd200, 16'sd50, 16'sd300};
  logic signed [15:0] bps [4] = '{16'sd100, 16'sd200, -16'sd50, 16'sd0};
  logic signed [15:0] lps [4] = '{16'sd50, 16'sd150, 16'sd75, -16'sd25};

  efb_coef_bank i_efb_coef_bank (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .ECHO_VALID(echo_valid),
    .ECHO_DATA(echo_data), .BP_VALID(bp_valid), .BP_DATA(bp_data),
    .LP_VALID(lp_valid), .LP_DATA(lp_data));

  efb_echo_src i_efb_echo_src (.clk(sys_clk), .valid(echo_valid), .data(echo_data));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [EFB_AW-1:0] addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // No fixed latency assumed; the watchdog ends a stuck wait
  task automatic apb(input logic wr, input logic [EFB_AW-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rdo, output logic erro);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdo = prdata;
    erro = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog, tests
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, addr(rows[i].idx), 32'h0, rd, er);
      chk("reset value", 32'h0, rd);
    end
    $display("test reset values done");
    foreach (rows[i]) apb(1'b1, addr(rows[i].idx), rows[i].wdata, rd, er);
    foreach (rows[i]) begin
      apb(1'b0, addr(rows[i].idx), 32'h0, rd, er);
      chk("readback", {24'h0, rows[i].rexp}, rd);
      chk("slverr", 32'h0, {31'h0, er});
    end
    $display("test register rows done");
    apb(1'b1, addr(8'h98), 32'h77, rd, er);
    chk("unmapped write slverr", 32'h1, {31'h0, er});
    apb(1'b0, addr(8'h98), 32'h0, rd, er);
    chk("unmapped read data", 32'h0, rd);
    apb(1'b0, addr(8'h92) + 12'h001, 32'h0, rd, er);
    chk("unaligned slverr", 32'h1, {31'h0, er});
    $display("test unmapped done");
    foreach (rows[i]) apb(1'b1, addr(rows[i].idx), {24'h0, rows[i].fval}, rd, er);
    for (int i = 0; i < 4; i++) begin
      // Last sample: bandpass gain cleared just before it
      if (i == 3) apb(1'b1, addr(8'h92), 32'h0, rd, er);
      i_efb_echo_src.push(xs[i]);
      @(posedge sys_clk);
      chk("bp valid", 32'h1, {31'h0, bp_valid});
      chk("bp data", 32'(bps[i]), 32'(bp_data));
      @(posedge sys_clk);
      chk("bp pulse", 32'h0, {31'h0, bp_valid});
      chk("lp valid", 32'h1, {31'h0, lp_valid});
      chk("lp data", 32'(lps[i]), 32'(lp_data));
    end
    $display("test filter samples done");
    // Reset in mid-run must clear every byte and the filter history
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, addr(rows[i].idx), 32'h0, rd, er);
      chk("value after second reset", 32'h0, rd);
    end
    i_efb_echo_src.push(16'sd1000);
    @(posedge sys_clk);
    chk("zero coef bp valid", 32'h1, {31'h0, bp_valid});
    chk("zero coef bp data", 32'h0, 32'(bp_data));
    @(posedge sys_clk);
    chk("zero coef lp data", 32'h0, 32'(lp_data));
    $display("test mid-run reset done");
    finish_test();
  end
endmodule

`default_nettype wire
